// *** hw/tbid_pkg.sv ***
// Shared constants and types of the twelve-bit instruction decoder
package tbid_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned PC_W = 10;
  localparam int unsigned GPIO_W = 6;
  localparam int unsigned WDT_W = 22;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WDT_PERIOD_NS = 18000000;
  localparam int unsigned WDT_CYCLES_DEF = WDT_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // File addresses and special words
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_TMR = 5'h01;
  localparam logic [4:0] ADDR_PCL = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_GPIO = 5'h06;
  localparam logic [11:0] WORD_NOP = 12'h000;
  localparam logic [11:0] WORD_OPTION = 12'h002;
  localparam logic [11:0] WORD_SLEEP = 12'h003;
  localparam logic [11:0] WORD_CLR_WATCHDOG = 12'h004;
  localparam logic [8:0] DIR_PREFIX = 9'h000;
  localparam logic [2:0] DIR_PORT = 3'h6;
  localparam logic [PC_W-1:0] RESET_VECTOR = 10'h000;
  localparam logic [PC_W-1:0] PC_BIT8_MASK = 10'h100;

  // ----------------------------------------------------------------
  // Opcode groups and fields
  // ----------------------------------------------------------------
  localparam logic [1:0] GRP_BYTE = 2'h0, GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_CTRL = 2'h2, GRP_LIT = 2'h3;
  localparam logic [3:0] F_MISC = 4'h0, F_CLR = 4'h1, F_SUB = 4'h2;
  localparam logic [3:0] F_DEC = 4'h3, F_OR = 4'h4, F_AND = 4'h5;
  localparam logic [3:0] F_XOR = 4'h6, F_ADD = 4'h7, F_MOV = 4'h8;
  localparam logic [3:0] F_COM = 4'h9, F_INC = 4'hA, F_DECSZ = 4'hB;
  localparam logic [3:0] F_ROR = 4'hC, F_ROL = 4'hD, F_SWAP = 4'hE;
  localparam logic [3:0] F_INCSZ = 4'hF;
  localparam logic [1:0] B_CLR = 2'h0, B_SET = 2'h1;
  localparam logic [1:0] B_TSTC = 2'h2, B_TSTS = 2'h3;
  localparam logic [1:0] C_RET = 2'h0, C_CALL = 2'h1;
  localparam logic [1:0] L_MOV = 2'h0, L_OR = 2'h1;
  localparam logic [1:0] L_AND = 2'h2, L_XOR = 2'h3;

  // ----------------------------------------------------------------
  // Register layouts and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsvd;
    logic page;
    logic timeout_flag;
    logic powerdown_flag;
    logic z;
    logic dc;
    logic c;
  } tbid_status_t;

  typedef struct packed {
    logic wake_dis;
    logic pullup_dis;
    logic t0_src;
    logic t0_edge;
    logic psa_wdt;
    logic [2:0] ps;
  } tbid_option_t;

  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [GPIO_W-1:0] DIR_RST = 6'h3F;
  localparam logic [7:0] STATUS_RST = 8'h18;

endpackage

// *** hw/tbid_file_ram.sv ***
// General purpose file register memory with registered read data
`timescale 1ns/100ps
module tbid_file_ram (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] raddr_i,
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem [32];

  // Storage write
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read, same-cycle write passes through
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

// *** hw/tbid_core.sv ***
// Instruction decoder and execution core of a small 8-bit processor
//
// Summary of operation
// - Clear-watchdog resets watchdog counter and assigned postscaler.
// - Sleep also resets watchdog counter and assigned postscaler.
// - Word 003 enters sleep, 004 clears watchdog; both set timeout flag, only 004 sets powerdown flag.
// - Byte ops take 5-bit file address; d=0 writes accumulator, d=1 file.
// - OR, AND, XOR with file register in one cycle, zero flag only.
// - Decrement/increment file, skip next when zero, flags untouched.
// - Rotate left/right through carry, only carry changes.
// - Bit clear, set, and test-with-skip on indexed bit of file.
// - Literal OR/AND/XOR affect zero only; literal load keeps flags.
// - Return loads literal into accumulator and pops return address.
// - Every program counter write except jump clears counter bit 8.
// - Direction load with operand 6 copies accumulator to direction latches.
// - A direction bit of one disables that pin's output driver.
// - Read-modify-write of the port uses sampled pin levels.
// - Writing the timer clears the prescaler when assigned to it.
// - Word 002 loads prescale configuration; every reset sets it FF.
`timescale 1ns/100ps
module tbid_core #(
  parameter int unsigned WDT_CYCLES = tbid_pkg::WDT_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] instr_i,
  input wire logic [tbid_pkg::GPIO_W-1:0] gpio_in_i,
  output logic [tbid_pkg::PC_W-1:0] pc_o,
  output logic [tbid_pkg::GPIO_W-1:0] gpio_out_o,
  output logic [tbid_pkg::GPIO_W-1:0] gpio_oe_o,
  output logic sleep_o,
  output logic wdt_reset_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam logic [tbid_pkg::WDT_W-1:0] WDT_LAST =
    tbid_pkg::WDT_W'(WDT_CYCLES - 1);

  function automatic logic [8:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic cin);
    add8 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  function automatic logic nib_carry(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic cin);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    nib_carry = s[4];
  endfunction

  function automatic logic [tbid_pkg::PC_W-1:0] clr_bit8(
    input logic [tbid_pkg::PC_W-1:0] p);
    clr_bit8 = p & ~tbid_pkg::PC_BIT8_MASK;
  endfunction

  function automatic logic [7:0] psc_limit(input tbid_pkg::tbid_option_t o);
    logic [8:0] span;
    span = 9'h001 << ({1'b0, o.ps} + {3'h0, ~o.psa_wdt});
    psc_limit = 8'(span - 9'h001);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [11:0] ir;
  logic [7:0] w;
  tbid_pkg::tbid_status_t st;
  tbid_pkg::tbid_option_t opt;
  logic [tbid_pkg::PC_W-1:0] stack0, stack1;
  logic [7:0] tmr, psc;
  logic [tbid_pkg::WDT_W-1:0] wdt_cnt;
  logic [tbid_pkg::GPIO_W-1:0] sync1, sync2, sync3, pin_level;
  logic [7:0] rdata;

  // Decode results
  logic [4:0] faddr;
  logic [7:0] fval, result, lit;
  logic wr_w, wr_f, upd_z, upd_c, upd_dc, new_c, new_dc, skip, jump;
  logic is_call, is_ret, is_sleep, is_clr_wd, is_option, is_dir_load;
  logic [tbid_pkg::PC_W-1:0] target;
  logic run, wdt_tick, wdt_fire, tmr_wr, mem_we;

  tbid_file_ram u_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raddr_i(instr_i[4:0]),
    .we_i(mem_we),
    .waddr_i(faddr),
    .wdata_i(result),
    .rdata_o(rdata)
  );

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Three-stage sampler, level accepted once the last two agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_level <= '0;
    end else begin
      sync1 <= gpio_in_i;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_level <= (sync2 & sync3) | (pin_level & (sync2 ^ sync3));
    end
  end

  // ----------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------
  // Operand source, port reads see the pins
  always_comb begin
    faddr = ir[4:0];
    lit = ir[7:0];
    case (faddr)
      tbid_pkg::ADDR_TMR: fval = tmr;
      tbid_pkg::ADDR_PCL: fval = pc_o[7:0];
      tbid_pkg::ADDR_STATUS: fval = st;
      tbid_pkg::ADDR_GPIO: fval = {2'h0, pin_level};
      default: fval = rdata;
    endcase
  end

  // Operation decode and result
  always_comb begin
    result = w;
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    new_c = st.c;
    new_dc = st.dc;
    skip = 1'b0;
    jump = 1'b0;
    target = pc_o;
    is_call = 1'b0;
    is_ret = 1'b0;
    is_sleep = (ir == tbid_pkg::WORD_SLEEP);
    is_clr_wd = (ir == tbid_pkg::WORD_CLR_WATCHDOG);
    is_option = (ir == tbid_pkg::WORD_OPTION);
    is_dir_load = (ir[11:3] == tbid_pkg::DIR_PREFIX) &&
                  (ir[2:0] == tbid_pkg::DIR_PORT);
    case (ir[11:10])
      tbid_pkg::GRP_BYTE: begin
        // Destination bit picks accumulator or file
        wr_w = ~ir[5];
        wr_f = ir[5];
        case (ir[9:6])
          tbid_pkg::F_MISC: begin
            result = w;
            wr_w = 1'b0;
          end
          tbid_pkg::F_CLR: begin
            result = 8'h00;
            upd_z = 1'b1;
          end
          tbid_pkg::F_SUB: begin
            {new_c, result} = add8(fval, ~w, 1'b1);
            new_dc = nib_carry(fval, ~w, 1'b1);
            upd_z = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          tbid_pkg::F_DEC: begin
            result = fval - 8'h01;
            upd_z = 1'b1;
          end
          tbid_pkg::F_OR: begin
            result = w | fval;
            upd_z = 1'b1;
          end
          tbid_pkg::F_AND: begin
            result = w & fval;
            upd_z = 1'b1;
          end
          tbid_pkg::F_XOR: begin
            result = w ^ fval;
            upd_z = 1'b1;
          end
          tbid_pkg::F_ADD: begin
            {new_c, result} = add8(fval, w, 1'b0);
            new_dc = nib_carry(fval, w, 1'b0);
            upd_z = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          tbid_pkg::F_MOV: begin
            result = fval;
            upd_z = 1'b1;
          end
          tbid_pkg::F_COM: begin
            result = ~fval;
            upd_z = 1'b1;
          end
          tbid_pkg::F_INC: begin
            result = fval + 8'h01;
            upd_z = 1'b1;
          end
          tbid_pkg::F_DECSZ: begin
            result = fval - 8'h01;
            skip = (result == 8'h00);
          end
          tbid_pkg::F_INCSZ: begin
            result = fval + 8'h01;
            skip = (result == 8'h00);
          end
          tbid_pkg::F_ROR: begin
            result = {st.c, fval[7:1]};
            new_c = fval[0];
            upd_c = 1'b1;
          end
          tbid_pkg::F_ROL: begin
            result = {fval[6:0], st.c};
            new_c = fval[7];
            upd_c = 1'b1;
          end
          tbid_pkg::F_SWAP: begin
            result = {fval[3:0], fval[7:4]};
          end
          default: begin
            result = w;
          end
        endcase
      end
      tbid_pkg::GRP_BIT: begin
        result = fval;
        case (ir[9:8])
          tbid_pkg::B_CLR: begin
            result[ir[7:5]] = 1'b0;
            wr_f = 1'b1;
          end
          tbid_pkg::B_SET: begin
            result[ir[7:5]] = 1'b1;
            wr_f = 1'b1;
          end
          tbid_pkg::B_TSTC: skip = ~fval[ir[7:5]];
          default: skip = fval[ir[7:5]];
        endcase
      end
      tbid_pkg::GRP_CTRL: begin
        jump = 1'b1;
        case (ir[9:8])
          tbid_pkg::C_RET: begin
            result = lit;
            wr_w = 1'b1;
            is_ret = 1'b1;
            target = clr_bit8(stack0);
          end
          tbid_pkg::C_CALL: begin
            is_call = 1'b1;
            target = clr_bit8({st.page, 1'b0, lit});
          end
          default: target = {st.page, ir[8:0]};
        endcase
      end
      default: begin
        wr_w = 1'b1;
        upd_z = (ir[9:8] != tbid_pkg::L_MOV);
        case (ir[9:8])
          tbid_pkg::L_OR: result = w | lit;
          tbid_pkg::L_AND: result = w & lit;
          tbid_pkg::L_XOR: result = w ^ lit;
          default: result = lit;
        endcase
      end
    endcase
    // A write to the low counter byte is a branch
    if (wr_f && (faddr == tbid_pkg::ADDR_PCL)) begin
      jump = 1'b1;
      target = clr_bit8({pc_o[9:8], result});
    end
  end

  // Watchdog and timer events
  always_comb begin
    run = ~sleep_o;
    wdt_tick = (wdt_cnt == WDT_LAST);
    wdt_fire = wdt_tick && (~opt.psa_wdt || (psc == psc_limit(opt)));
    tmr_wr = run && wr_f && (faddr == tbid_pkg::ADDR_TMR);
    mem_we = run && wr_f && ~wdt_fire && (faddr != tbid_pkg::ADDR_TMR) &&
             (faddr != tbid_pkg::ADDR_PCL) &&
             (faddr != tbid_pkg::ADDR_STATUS) &&
             (faddr != tbid_pkg::ADDR_GPIO);
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Fetch, counter and return stack; flushed slots become idle words
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_o <= tbid_pkg::RESET_VECTOR;
      ir <= tbid_pkg::WORD_NOP;
      stack0 <= '0;
      stack1 <= '0;
    end else if (wdt_fire) begin
      pc_o <= tbid_pkg::RESET_VECTOR;
      ir <= tbid_pkg::WORD_NOP;
    end else if (~run || is_sleep) begin
      ir <= tbid_pkg::WORD_NOP;
    end else begin
      if (jump) begin
        pc_o <= target;
        ir <= tbid_pkg::WORD_NOP;
      end else begin
        pc_o <= pc_o + 10'h001;
        ir <= skip ? tbid_pkg::WORD_NOP : instr_i;
      end
      if (is_call) begin
        stack0 <= pc_o;
        stack1 <= stack0;
      end else if (is_ret) begin
        stack0 <= stack1;
      end
    end
  end

  // Accumulator
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      w <= 8'h00;
    end else if (run && ~wdt_fire && wr_w) begin
      w <= result;
    end
  end

  // Status flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= tbid_pkg::STATUS_RST;
    end else if (wdt_fire) begin
      st.timeout_flag <= 1'b0;
      st.page <= 1'b0;
    end else if (run) begin
      if (wr_f && (faddr == tbid_pkg::ADDR_STATUS)) begin
        st.page <= result[5];
        st.z <= result[2];
        st.dc <= result[1];
        st.c <= result[0];
      end
      if (upd_z) begin
        st.z <= (result == 8'h00);
      end
      if (upd_c) begin
        st.c <= new_c;
      end
      if (upd_dc) begin
        st.dc <= new_dc;
      end
      if (is_clr_wd || is_sleep) begin
        st.timeout_flag <= 1'b1;
        st.powerdown_flag <= ~is_sleep;
      end
    end
  end

  // Prescale configuration and direction latches, restored on any reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      opt <= tbid_pkg::OPTION_RST;
      gpio_oe_o <= ~tbid_pkg::DIR_RST;
    end else if (wdt_fire) begin
      opt <= tbid_pkg::OPTION_RST;
      gpio_oe_o <= ~tbid_pkg::DIR_RST;
    end else if (run) begin
      if (is_option) begin
        opt <= w;
      end
      if (is_dir_load) begin
        gpio_oe_o <= ~w[tbid_pkg::GPIO_W-1:0];
      end
    end
  end

  // Port output latch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gpio_out_o <= '0;
    end else if (run && ~wdt_fire && wr_f &&
                 (faddr == tbid_pkg::ADDR_GPIO)) begin
      gpio_out_o <= result[tbid_pkg::GPIO_W-1:0];
    end
  end

  // Timer and shared prescaler
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr <= 8'h00;
      psc <= 8'h00;
    end else if (wdt_fire) begin
      psc <= 8'h00;
    end else if (tmr_wr) begin
      tmr <= result;
      if (~opt.psa_wdt) begin
        psc <= 8'h00;
      end
    end else if ((is_clr_wd || is_sleep) && run && opt.psa_wdt) begin
      psc <= 8'h00;
    end else if (opt.psa_wdt) begin
      if (wdt_tick) begin
        psc <= psc + 8'h01;
      end
    end else if (~opt.t0_src && run) begin
      if (psc == psc_limit(opt)) begin
        psc <= 8'h00;
        tmr <= tmr + 8'h01;
      end else begin
        psc <= psc + 8'h01;
      end
    end
  end

  // Watchdog counter, sleep state and reset pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_cnt <= '0;
      sleep_o <= 1'b0;
      wdt_reset_o <= 1'b0;
    end else begin
      wdt_reset_o <= wdt_fire;
      if (wdt_fire) begin
        wdt_cnt <= '0;
        sleep_o <= 1'b0;
      end else if (run && (is_clr_wd || is_sleep)) begin
        wdt_cnt <= '0;
        sleep_o <= is_sleep;
      end else begin
        wdt_cnt <= wdt_tick ? '0 : wdt_cnt + 22'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_wd_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && is_clr_wd && ~wdt_fire) |=> (wdt_cnt == '0) && st.timeout_flag
    && st.powerdown_flag) else $error("watchdog not cleared");
  chk_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && is_sleep && ~wdt_fire) |=> sleep_o && (wdt_cnt == '0)
    && ~st.powerdown_flag) else $error("sleep entry wrong");
  chk_sleep_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_o && ~wdt_fire) |=> $stable(pc_o) && (ir == tbid_pkg::WORD_NOP))
    else $error("core ran during sleep");
  chk_skip_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && skip && ~jump && ~wdt_fire) |=> (ir == tbid_pkg::WORD_NOP)
    ##1 (pc_o == $past(pc_o, 2) + 10'h002)) else $error("skip not idled");
  chk_option_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && is_option && ~wdt_fire) |=> (opt == $past(w)))
    else $error("prescale config not loaded");
  chk_option_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    wdt_fire |=> (opt == tbid_pkg::OPTION_RST) && wdt_reset_o)
    else $error("prescale config not restored");
  chk_dir_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && is_dir_load && ~wdt_fire) |=> (gpio_oe_o == ~$past(w[5:0])))
    else $error("direction latches wrong");
  chk_call_bit8: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && (is_call || is_ret) && ~wdt_fire) |=> ~pc_o[8])
    else $error("counter bit 8 not cleared");
  chk_pc_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && ~jump && ~is_sleep && ~wdt_fire) |=> (pc_o == $past(pc_o) + 10'h001))
    else $error("counter did not advance");
  chk_literal_xor: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && (ir[11:8] == 4'hF) && ~wdt_fire) |=> (w == ($past(w) ^ $past(lit)))
    && (st.z == (w == 8'h00))) else $error("literal xor wrong");
  chk_return_lit: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && is_ret && ~wdt_fire) |=> (w == $past(lit))
    && (pc_o == clr_bit8($past(stack0)))) else $error("return wrong");
  chk_rotate_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && (ir[11:6] == 6'h0D) && ~wdt_fire) |=> (st.c == $past(fval[7]))
    && $stable(st.z)) else $error("rotate carry wrong");

endmodule

// *** tb/tbid_pmem.sv ***
// Program memory model feeding the core's fetch port
`timescale 1ns/100ps
module tbid_pmem (
  input wire logic [tbid_pkg::PC_W-1:0] pc_i,
  output logic [11:0] instr_o
);
  // ----------------------------------------------------------------
  // Word storage, loaded by the bench
  // ----------------------------------------------------------------
  logic [11:0] rom [0:1023];
  // Unwritten words act as no-op
  initial begin
    for (int i = 0; i < 1024; i++) rom[i] = tbid_pkg::WORD_NOP;
  end
  // One 12-bit word at the fetch address, same cycle
  assign instr_o = rom[pc_i];
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the instruction decoder core
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------
  // Signals and design hookup
  // ----------------------------------------------------------------
  localparam logic [11:0] OPS [18] = '{12'h100, 12'h140, 12'h180,
    12'h380, 12'h340, 12'h300, 12'h2C0, 12'h3C0, 12'h400, 12'h500,
    12'h600, 12'h700, 12'hD00, 12'hE00, 12'hF00, 12'hC00, 12'h9FF,
    12'h206};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [tbid_pkg::GPIO_W-1:0] gpio_in = 6'h00;
  logic [tbid_pkg::GPIO_W-1:0] gpio_out, gpio_oe;
  logic [tbid_pkg::PC_W-1:0] pc;
  logic [11:0] instr;
  logic sleep, wdt_rst;
  logic [16:0] seed = 17'h124B1;
  logic [5:0] q_out [$];
  logic [5:0] q_oe [$];
  logic [5:0] prev_out = 6'h00;
  logic [5:0] prev_oe = 6'h00;
  logic [5:0] last = 6'h00;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int p = 0;
  // Core clock, 8 ns period
  always #4 clk_i = ~clk_i;
  tbid_pmem PM (.pc_i(pc), .instr_o(instr));
  tbid_core #(.WDT_CYCLES(16)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .instr_i(instr), .gpio_in_i(gpio_in), .pc_o(pc),
    .gpio_out_o(gpio_out), .gpio_oe_o(gpio_oe), .sleep_o(sleep),
    .wdt_reset_o(wdt_rst));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cmp6(input logic [5:0] got, input logic [5:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp6({5'h00, got}, {5'h00, exp});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    for (int i = 0; i < 8; i++) seed = {seed[15:0], seed[16] ^ seed[13]};
    return seed[7:0];
  endfunction
  task automatic put(input logic [11:0] w);
    PM.rom[p] = w;
    p++;
  endtask
  task automatic wait_hi(input bit pick, output int n);
    n = 0;
    while ((pick ? wdt_rst : sleep) !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  // Expected accumulator after one segment, then optional xor 15
  function automatic logic [7:0] model(input int k, input logic [7:0] a,
    input logic [7:0] b, input logic c, input logic [2:0] n);
    logic [7:0] r;
    logic sk;
    sk = 1'b0;
    case (k)
      0: r = a | b;
      1: r = a & b;
      2: r = a ^ b;
      3: r = {a[3:0], a[7:4]};
      4: r = {a[6:0], c};
      5: r = {c, a[7:1]};
      6, 7: begin
        r = (k == 6) ? a - 8'h01 : a + 8'h01;
        sk = (r == 8'h00);
      end
      8: r = a & ~(8'h01 << n);
      9: r = a | (8'h01 << n);
      10, 11: begin
        r = b;
        sk = (a[n] == (k == 11));
      end
      12: r = b | a;
      13: r = b & a;
      14: r = b ^ a;
      15, 16: r = a;
      default: r = {2'h0, gpio_in};
    endcase
    return sk ? r : r ^ 8'h15;
  endfunction
  // Result watcher: each port change takes the oldest note
  always @(negedge clk_i) if (!rst_i) begin
    if (gpio_out !== prev_out) begin
      cmp6(gpio_out, q_out.size() ? q_out.pop_front() : ~gpio_out);
      prev_out = gpio_out;
    end
    if (gpio_oe !== prev_oe) begin
      cmp6(gpio_oe, q_oe.size() ? q_oe.pop_front() : ~gpio_oe);
      prev_oe = gpio_oe;
    end
  end
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 12000) begin
      bad_count++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Program build and run
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] a, b, r;
    logic [11:0] w;
    logic c, d;
    logic [2:0] n;
    int t, lp;
    // Let the program memory fill itself with idle words first
    @(negedge clk_i);
    r = rnd();
    gpio_in = r[5:0];
    for (int k = 0; k < 18; k++) begin
      a = rnd();
      b = rnd();
      r = rnd();
      c = r[0];
      n = r[3:1];
      d = (k < 6) ? r[4] : (k == 8 || k == 9);
      if ((k == 6 || k == 7) && r[5]) a = (k == 6) ? 8'h01 : 8'hFF;
      w = OPS[k];
      if (k < 12) w = w | 12'h010 | (k < 8 ? {6'h00, d, 5'h00} : {4'h0, n, 5'h00});
      if (k >= 12 && k < 16) w = w | {4'h0, a};
      if (k == 16) PM.rom[255] = {4'h8, a};
      put(c ? 12'h503 : 12'h403);
      put({4'hC, a});
      put(12'h030);
      put({4'hC, b});
      put(w);
      if (d) put(12'h210);
      put(12'hF15);
      put(12'h026);
      r = model(k, a, b, c, n);
      if (r[5:0] !== last) q_out.push_back(r[5:0]);
      last = r[5:0];
    end
    r = rnd() & 8'hFE;
    put({4'hC, r});
    put(12'h006);
    q_oe.push_back(~r[5:0]);
    q_oe.push_back(6'h00);
    lp = p;
    put(12'h004);
    put({3'h5, lp[8:0]});
    put(12'hC08);
    put(12'h002);
    put(12'h003);
    PM.rom[224] = 12'h003;
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    t = 0;
    while (pc !== lp[9:0] && t < 1000) begin
      @(negedge clk_i);
      t++;
    end
    cmp_bit(t < 1000, 1'b1);
    t = 0;
    repeat (3000) begin
      @(negedge clk_i);
      if (wdt_rst === 1'b1) t++;
    end
    cmp_bit(t == 0, 1'b1);
    PM.rom[lp + 1] = tbid_pkg::WORD_NOP;
    PM.rom[0] = 12'hAE0;
    wait_hi(1'b0, t);
    cmp_bit(t < 20, 1'b1);
    wait_hi(1'b1, t);
    cmp_bit(t >= 8 && t <= 40, 1'b1);
    wait_hi(1'b0, t);
    wait_hi(1'b1, t);
    cmp_bit(t >= 1900 && t <= 2200, 1'b1);
    cmp_bit(q_out.size() == 0 && q_oe.size() == 0, 1'b1);
    close_out();
  end
endmodule
